// [logic/hw_monitor.sv]
// Hardware monitor core: channel sequencer, fan tachometers, limits.
// Assumes an external 8-bit converter on ref_clk with a done strobe,
// and open-drain pads outside for sda and the alert line.
`timescale 1ns/1ns
// Notes on behaviour
// - Round-robin conversion of all slots once started
// - Fans measured in parallel with sequencer
// - Results stored in readable value registers
// - Limit compare sets status bits
// - Out-of-limit event asserts interrupt output
// - Mask bits suppress status onto interrupt
// - Intrusion latched in battery-backed bit
// - One shared 8-bit converter for slots
// - Remote 2 pins: temperature or analog
// - Pointer selects accessed register
// - First written byte loads pointer
// - Configuration only through serial bus
// - Per-fan prescaler from divisor registers
module hw_monitor #(
  parameter int NUM_SLOT = monitor_pkg::NUM_SLOT,
  parameter int NUM_FAN = monitor_pkg::NUM_FAN,
  parameter int TICK_CYCLES = monitor_pkg::FAN_TICK_CYCLES,
  parameter logic [6:0] DEV_ADDR = monitor_pkg::DEV_ADDR_DEFAULT
) (
  // Clock and resets
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic bat_rst,
  // Serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Converter
  output logic adc_start,
  output logic [4:0] adc_chan,
  output logic adc_temp,
  input wire logic adc_done,
  input wire logic [7:0] adc_data,
  // Sensor pins
  input wire logic [NUM_FAN-1:0] fan_i,
  input wire logic intrude_i,
  // Interrupt
  output logic alert_n
);
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001, SEQ_CONV = 3'b010, SEQ_WAIT = 3'b100
  } seq_type;
  seq_type seq_reg, seq_next;
  // Bus side
  logic wr_en;
  logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
  // Software state
  logic [7:0] cfg_reg;
  logic [15:0] fdiv_reg;
  logic [31:0] mask_reg, stat_reg, stat_next, clr_vec, set_vec;
  logic [7:0] hi_mem [NUM_SLOT];
  logic [7:0] lo_mem [NUM_SLOT];
  logic [7:0] val_mem [NUM_SLOT];
  logic [7:0] flim_mem [NUM_FAN];
  logic [7:0] fan_val_w [NUM_FAN];
  logic [NUM_FAN-1:0] fan_set, fan_s1_reg, fan_s2_reg;
  logic [4:0] slot_reg;
  logic intr_s1_reg, intr_s2_reg, intrude_reg, alert_n_reg;
  logic [11:0] tick_cnt_reg;

  smbus_slave #(.DEV_ADDR(DEV_ADDR)) bus_u (
    .ref_clk(ref_clk),
    .rst(rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // Write decode; the bus is the only path into control state
  wire wr_cfg = wr_en && wr_addr == monitor_pkg::CFG_ADDR;
  wire [7:0] hi_off = wr_addr - monitor_pkg::HI_BASE;
  wire [7:0] lo_off = wr_addr - monitor_pkg::LO_BASE;
  wire [7:0] fl_off = wr_addr - monitor_pkg::FLIM_BASE;
  wire wr_hi = wr_en && hi_off < 8'(NUM_SLOT);
  wire wr_lo = wr_en && lo_off < 8'(NUM_SLOT);
  wire wr_fl = wr_en && fl_off < 8'(NUM_FAN);
  wire [1:0] fd_sel;
  wire [3:0] st_sel, mk_sel;
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_byte
      assign st_sel[b] = wr_en && wr_addr == monitor_pkg::STAT_ADDR + 8'(b);
      assign mk_sel[b] = wr_en && wr_addr == monitor_pkg::MASK_ADDR + 8'(b);
      assign clr_vec[8*b+:8] = st_sel[b] ? wr_data : 8'h00;
    end
    for (b = 0; b < 2; b++) begin : g_fdiv
      assign fd_sel[b] = wr_en && wr_addr == monitor_pkg::FDIV_ADDR + 8'(b);
    end
  endgenerate

  // Control registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_reg <= monitor_pkg::CFG_RESET;
      fdiv_reg <= monitor_pkg::FDIV_RESET;
      mask_reg <= monitor_pkg::MASK_RESET;
    end else begin
      if (wr_cfg) cfg_reg <= {1'b0, wr_data[6:0]};
      for (int i = 0; i < 2; i++) if (fd_sel[i]) fdiv_reg[8*i+:8] <= wr_data;
      for (int i = 0; i < 4; i++) if (mk_sel[i]) mask_reg[8*i+:8] <= wr_data;
    end
  end

  // Limit memories, no reset on the data path beyond init values
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_SLOT; i++) hi_mem[i] <= monitor_pkg::HI_RESET;
      for (int i = 0; i < NUM_SLOT; i++) lo_mem[i] <= monitor_pkg::LO_RESET;
      for (int i = 0; i < NUM_FAN; i++) flim_mem[i] <= monitor_pkg::FLIM_RESET;
    end else begin
      if (wr_hi) hi_mem[hi_off[4:0]] <= wr_data;
      if (wr_lo) lo_mem[lo_off[4:0]] <= wr_data;
      if (wr_fl) flim_mem[fl_off[2:0]] <= wr_data;
    end
  end

  // Sequencer decode: slot 19 kind follows the remote 2 mode
  wire rt2_analog = cfg_reg[monitor_pkg::CFG_RT2_ANALOG_BIT];
  wire seq_run = cfg_reg[monitor_pkg::CFG_START_BIT];
  wire store = (seq_reg == SEQ_WAIT) && adc_done;
  wire oor = adc_data > hi_mem[slot_reg] || adc_data < lo_mem[slot_reg];
  wire [4:0] slot_inc = (slot_reg == monitor_pkg::LAST_SLOT) ? 5'h00 : slot_reg + 5'h01;
  assign adc_start = seq_reg == SEQ_CONV;
  assign adc_chan = slot_reg;
  assign adc_temp = slot_reg >= monitor_pkg::TEMP_SLOT &&
                    !(slot_reg == monitor_pkg::RT2_SLOT && rt2_analog);

  // Sequencer next state
  always_comb begin
    seq_next = seq_reg;
    unique case (seq_reg)
      SEQ_IDLE: if (seq_run) seq_next = SEQ_CONV;
      SEQ_CONV: seq_next = SEQ_WAIT;
      SEQ_WAIT: if (adc_done) seq_next = seq_run ? SEQ_CONV : SEQ_IDLE;
    endcase
  end

  // Sequencer state and result store
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      seq_reg <= SEQ_IDLE;
      slot_reg <= 5'h00;
      for (int i = 0; i < NUM_SLOT; i++) val_mem[i] <= 8'h00;
    end else begin
      seq_reg <= seq_next;
      if (store) begin
        val_mem[slot_reg] <= adc_data;
        slot_reg <= slot_inc;
      end
    end
  end

  // Fan timebase shared by all tachometers
  wire base_tick = tick_cnt_reg == 12'(TICK_CYCLES - 1);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) tick_cnt_reg <= 12'h000;
    else tick_cnt_reg <= base_tick ? 12'h000 : tick_cnt_reg + 12'h001;
  end

  // Two-flop sync of fan and intrusion pins
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fan_s1_reg <= '1;
      fan_s2_reg <= '1;
      {intr_s1_reg, intr_s2_reg} <= 2'h0;
    end else begin
      fan_s1_reg <= fan_i;
      fan_s2_reg <= fan_s1_reg;
      {intr_s1_reg, intr_s2_reg} <= {intrude_i, intr_s1_reg};
    end
  end

  // One tachometer per fan, free of the sequencer
  genvar f;
  generate
    for (f = 0; f < NUM_FAN; f++) begin : g_fan
      logic prev_reg, fall;
      logic [2:0] pre_reg, pre_top;
      logic [7:0] cnt_reg, val_reg;
      logic set_reg, tick;
      assign pre_top = 3'((4'h1 << fdiv_reg[2*f+:2]) - 4'h1);
      assign tick = base_tick && pre_reg == pre_top;
      assign fall = prev_reg & ~fan_s2_reg[f];
      assign fan_val_w[f] = val_reg;
      assign fan_set[f] = set_reg;
      // Count prescaled ticks over one tach period; slow fan saturates
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          {prev_reg, set_reg} <= 2'b10;
          pre_reg <= 3'h0;
          cnt_reg <= 8'h00;
          val_reg <= 8'h00;
        end else begin
          prev_reg <= fan_s2_reg[f];
          if (base_tick) pre_reg <= tick ? 3'h0 : pre_reg + 3'h1;
          set_reg <= fall && cnt_reg >= flim_mem[f];
          if (fall) begin
            val_reg <= cnt_reg;
            cnt_reg <= 8'h00;
          end else if (tick && cnt_reg != 8'hFF) begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
      end
    end
  endgenerate

  // Sticky status: hardware set beats software clear
  always_comb begin
    set_vec = 32'h00000000;
    set_vec[NUM_SLOT-1:0] = store ? (NUM_SLOT'(oor) << slot_reg) : '0;
    set_vec[monitor_pkg::FAN_STAT_BIT+:NUM_FAN] = fan_set;
    set_vec[monitor_pkg::INTRUDE_STAT_BIT] = intr_s2_reg;
    stat_next = (stat_reg & ~clr_vec) | set_vec;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stat_reg <= 32'h00000000;
      alert_n_reg <= 1'b1;
    end else begin
      stat_reg <= stat_next;
      alert_n_reg <= ~|(stat_reg & ~mask_reg);
    end
  end
  assign alert_n = alert_n_reg;
  // Unmasked status; alert_n shows its OR one cycle later
  wire [31:0] live_stat = stat_reg & ~mask_reg;

  // Intrusion latch lives on the battery reset only
  wire intr_clr = wr_cfg && wr_data[monitor_pkg::CFG_INTRUDE_BIT];
  always_ff @(posedge ref_clk or posedge bat_rst) begin
    if (bat_rst) intrude_reg <= 1'b0;
    else intrude_reg <= intr_s2_reg | (intrude_reg & ~intr_clr);
  end

  // Read mux at the pointer
  wire [7:0] r_val = rd_addr - monitor_pkg::VAL_BASE;
  wire [7:0] r_fv = rd_addr - monitor_pkg::FVAL_BASE;
  wire [7:0] r_st = rd_addr - monitor_pkg::STAT_ADDR;
  wire [7:0] r_mk = rd_addr - monitor_pkg::MASK_ADDR;
  always_comb begin
    rd_data = 8'h00;
    if (rd_addr == monitor_pkg::CFG_ADDR) rd_data = {intrude_reg, cfg_reg[6:0]};
    else if (rd_addr == monitor_pkg::FDIV_ADDR) rd_data = fdiv_reg[7:0];
    else if (rd_addr == monitor_pkg::FDIV_ADDR + 8'h01) rd_data = fdiv_reg[15:8];
    else if (r_st < 8'h04) rd_data = stat_reg[8*r_st[1:0]+:8];
    else if (r_mk < 8'h04) rd_data = mask_reg[8*r_mk[1:0]+:8];
    else if (r_val < 8'(NUM_SLOT)) rd_data = val_mem[r_val[4:0]];
    else if (r_fv < 8'(NUM_FAN)) rd_data = fan_val_w[r_fv[2:0]];
    else if (rd_addr - monitor_pkg::HI_BASE < 8'(NUM_SLOT))
      rd_data = hi_mem[5'(rd_addr - monitor_pkg::HI_BASE)];
    else if (rd_addr - monitor_pkg::LO_BASE < 8'(NUM_SLOT))
      rd_data = lo_mem[5'(rd_addr - monitor_pkg::LO_BASE)];
    else if (rd_addr - monitor_pkg::FLIM_BASE < 8'(NUM_FAN))
      rd_data = flim_mem[3'(rd_addr - monitor_pkg::FLIM_BASE)];
  end

  // Checks on the sequencer, status, alert, fan, config and intrusion paths
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  slot_order_a: assert property (store |=> slot_reg ==
    ($past(slot_reg) == monitor_pkg::LAST_SLOT ? 5'h00 : 5'($past(slot_reg) + 5'h01)))
    else $error("slot did not advance");
  conv_start_a: assert property (adc_start |=> !adc_start && seq_reg == SEQ_WAIT)
    else $error("converter start not single");
  val_store_a: assert property (store |=> val_mem[$past(slot_reg)] == $past(adc_data))
    else $error("value not stored");
  limit_stat_a: assert property (store && oor |=> stat_reg[$past(slot_reg)])
    else $error("out of limit not recorded");
  alert_or_a: assert property (1'b1 |=> alert_n == !(|$past(live_stat)))
    else $error("alert not OR of unmasked");
  mask_hold_a: assert property ((stat_reg & ~mask_reg) == 32'h0 |=> alert_n)
    else $error("masked status drives alert");
  sticky_a: assert property (stat_reg[0] && !clr_vec[0] |=> stat_reg[0])
    else $error("status bit lost");
  intrude_a: assert property (intr_s2_reg |=> intrude_reg ##1
    (intrude_reg || $past(intr_clr)))
    else $error("intrusion not latched");
  fan_lat_a: assert property (g_fan[0].fall |=> fan_val_w[0] == $past(g_fan[0].cnt_reg))
    else $error("fan count not latched");
  stat_clr_a: assert property (clr_vec[3] && !set_vec[3] |=> !stat_reg[3])
    else $error("status not cleared by write");
  set_win_a: assert property (set_vec[28] |=> stat_reg[28])
    else $error("set lost to clear");
  rt2_kind_a: assert property (slot_reg == monitor_pkg::RT2_SLOT |-> adc_temp == !rt2_analog)
    else $error("remote 2 kind wrong");
  cfg_bus_a: assert property (!wr_cfg |=> $stable(cfg_reg))
    else $error("config changed without bus");
  wrap_c: cover property (store && slot_reg == monitor_pkg::LAST_SLOT);
  fan_c: cover property (fan_set != '0 && seq_reg != SEQ_IDLE);
  alert_c: cover property ($fell(alert_n));
  rt2_c: cover property (store && slot_reg == monitor_pkg::RT2_SLOT && rt2_analog);
  intrude_c: cover property ($rose(intrude_reg));
endmodule // hw_monitor

// [pkg/monitor_pkg.sv]
// Shared constants for the hardware monitor core.
// Assumes a 50 MHz ref_clk; fan timebase times below are in ns, converted to ref_clk cycles.
package monitor_pkg;
  // Sizes
  localparam int NUM_SLOT = 20;
  localparam int NUM_FAN = 8;
  localparam int STAT_W = 32;
  // Slot roles: 0..16 voltages, 17 local temp, 18 remote temp, 19 remote 2
  localparam logic [4:0] TEMP_SLOT = 5'h11;
  localparam logic [4:0] RT2_SLOT = 5'h13;
  localparam logic [4:0] LAST_SLOT = 5'h13;
  // Status bit positions
  localparam int FAN_STAT_BIT = 20;
  localparam int INTRUDE_STAT_BIT = 28;
  // Register offsets
  localparam logic [7:0] CFG_ADDR = 8'h00;
  localparam logic [7:0] FDIV_ADDR = 8'h01;
  localparam logic [7:0] STAT_ADDR = 8'h04;
  localparam logic [7:0] MASK_ADDR = 8'h08;
  localparam logic [7:0] VAL_BASE = 8'h20;
  localparam logic [7:0] FVAL_BASE = 8'h38;
  localparam logic [7:0] HI_BASE = 8'h40;
  localparam logic [7:0] LO_BASE = 8'h60;
  localparam logic [7:0] FLIM_BASE = 8'h78;
  // Config bit positions
  localparam int CFG_START_BIT = 0;
  localparam int CFG_RT2_ANALOG_BIT = 1;
  localparam int CFG_INTRUDE_BIT = 7;
  // Reset values
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] HI_RESET = 8'hFF;
  localparam logic [7:0] LO_RESET = 8'h00;
  localparam logic [7:0] FLIM_RESET = 8'hFF;
  localparam logic [15:0] FDIV_RESET = 16'h5555;
  localparam logic [31:0] MASK_RESET = 32'h00000000;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2E;
  // Fan timebase
  localparam int REF_CLK_NS = 20;
  localparam int FAN_TICK_NS = 44000;
  localparam int FAN_TICK_CYCLES = FAN_TICK_NS / REF_CLK_NS;
endpackage

// [logic/smbus_slave.sv]
// Serial management bus slave with an address pointer.
// Assumes scl_i/sda_i are raw pins; the pad resolves sda from sda_oe.
`timescale 1ns/1ns
module smbus_slave #(
  parameter logic [6:0] DEV_ADDR = monitor_pkg::DEV_ADDR_DEFAULT
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Register side
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001, ST_ADDR = 7'b0000010, ST_ACKA = 7'b0000100,
    ST_WDAT = 7'b0001000, ST_ACKW = 7'b0010000, ST_RDAT = 7'b0100000,
    ST_ACKR = 7'b1000000
  } bus_state_type;
  bus_state_type state_reg, state_next;
  logic scl_s1_reg, scl_s2_reg, scl_d_reg, sda_s1_reg, sda_s2_reg, sda_d_reg;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] shift_reg, shift_next, ptr_reg, ptr_next, wa_reg, wa_next;
  logic [7:0] wd_reg, wd_next;
  logic rw_reg, rw_next, first_reg, first_next, oe_reg, oe_next, wr_reg, wr_next;
  // Edge and condition detection; first sync stage feeds only the second
  wire scl_rise = scl_s2_reg & ~scl_d_reg;
  wire scl_fall = ~scl_s2_reg & scl_d_reg;
  wire start_det = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
  wire stop_det = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;
  wire [7:0] shift_in = {shift_reg[6:0], sda_s2_reg};
  assign sda_o = 1'b0;
  assign sda_oe = oe_reg;
  assign wr_en = wr_reg;
  assign wr_addr = wa_reg;
  assign wr_data = wd_reg;
  assign rd_addr = ptr_reg;
  // Next-state logic of the byte engine
  always_comb begin
    state_next = state_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    wa_next = wa_reg;
    wd_next = wd_reg;
    rw_next = rw_reg;
    first_next = first_reg;
    oe_next = oe_reg;
    wr_next = 1'b0;
    if (stop_det) begin
      state_next = ST_IDLE;
      oe_next = 1'b0;
    end else if (start_det) begin
      // Repeated start also lands here
      state_next = ST_ADDR;
      bit_next = 3'h0;
      oe_next = 1'b0;
    end else if (scl_fall) begin
      // Change the drive when the master clock falls, or release it on start or stop; otherwise it is held through the high phase
      oe_next = (state_reg == ST_ACKA) | (state_reg == ST_ACKW) |
                ((state_reg == ST_RDAT) & ~shift_reg[7]);
    end else if (scl_rise) begin
      unique case (state_reg)
        ST_IDLE: begin
          state_next = ST_IDLE;
        end
        ST_ADDR: begin
          shift_next = shift_in;
          bit_next = bit_reg + 3'h1;
          if (bit_reg == 3'h7) begin
            rw_next = sda_s2_reg;
            state_next = (shift_reg[6:0] == DEV_ADDR) ? ST_ACKA : ST_IDLE;
          end
        end
        ST_ACKA: begin
          bit_next = 3'h0;
          first_next = 1'b1;
          state_next = rw_reg ? ST_RDAT : ST_WDAT;
          if (rw_reg) begin
            shift_next = rd_data;
          end
        end
        ST_WDAT: begin
          shift_next = shift_in;
          bit_next = bit_reg + 3'h1;
          if (bit_reg == 3'h7) begin
            state_next = ST_ACKW;
            first_next = 1'b0;
            if (first_reg) begin
              ptr_next = shift_in;
            end else begin
              wr_next = 1'b1;
              wa_next = ptr_reg;
              wd_next = shift_in;
              ptr_next = ptr_reg + 8'h01;
            end
          end
        end
        ST_ACKW: begin
          bit_next = 3'h0;
          state_next = ST_WDAT;
        end
        ST_RDAT: begin
          shift_next = {shift_reg[6:0], 1'b0};
          bit_next = bit_reg + 3'h1;
          if (bit_reg == 3'h7) begin
            state_next = ST_ACKR;
            ptr_next = ptr_reg + 8'h01;
          end
        end
        ST_ACKR: begin
          // Master ack keeps reading, nack ends the read
          bit_next = 3'h0;
          state_next = sda_s2_reg ? ST_IDLE : ST_RDAT;
          if (!sda_s2_reg) begin
            shift_next = rd_data;
          end
        end
      endcase
    end
  end
  // Pin synchronisers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {scl_s1_reg, scl_s2_reg, scl_d_reg} <= 3'h7;
      {sda_s1_reg, sda_s2_reg, sda_d_reg} <= 3'h7;
    end else begin
      {scl_s1_reg, scl_s2_reg, scl_d_reg} <= {scl_i, scl_s1_reg, scl_s2_reg};
      {sda_s1_reg, sda_s2_reg, sda_d_reg} <= {sda_i, sda_s1_reg, sda_s2_reg};
    end
  end
  // Engine state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      bit_reg <= 3'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      wa_reg <= 8'h00;
      wd_reg <= 8'h00;
      {rw_reg, first_reg, oe_reg, wr_reg} <= 4'h0;
    end else begin
      state_reg <= state_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      wa_reg <= wa_next;
      wd_reg <= wd_next;
      {rw_reg, first_reg, oe_reg, wr_reg} <= {rw_next, first_next, oe_next, wr_next};
    end
  end
  ptr_load_a: assert property (@(posedge ref_clk) disable iff (rst)
    (scl_rise && state_reg == ST_WDAT && bit_reg == 3'h7 && first_reg)
    |=> (ptr_reg == $past(shift_in) && !wr_en))
    else $error("pointer not loaded from first byte");
  wr_addr_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_en |-> (wr_addr == ptr_reg - 8'h01))
    else $error("write not at pointer");
endmodule // smbus_slave

// [verif/smbus_master_model.sv]
// Behavioural serial bus master that stands on the far side of the monitor.
// Assumes an open-drain sda resolved outside: sda_pull high pulls it low.
`timescale 1ns/1ns
module smbus_master_model (
  // Bus pins
  output logic scl,
  output logic sda_pull,
  input wire logic sda_line
);
  localparam int Q = 40; // Quarter of the 160 ns bus period

  // Bus idles released, clock high
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Start or repeated start, ends with scl low
  task automatic start();
    sda_pull = 1'b0; #Q; scl = 1'b1; #Q; sda_pull = 1'b1; #Q; scl = 1'b0; #Q;
  endtask

  // Stop, leaves the bus released
  task automatic stop();
    sda_pull = 1'b1; #Q; scl = 1'b1; #Q; sda_pull = 1'b0; #Q;
  endtask

  task automatic put_bit(input logic b);
    sda_pull = ~b; #Q; scl = 1'b1; #(2*Q); scl = 1'b0; #Q;
  endtask

  // Released line; sampled mid-high so a slow slave still makes it
  task automatic get_bit(output logic b);
    sda_pull = 1'b0; #Q; scl = 1'b1; #Q; b = sda_line; #Q; scl = 1'b0; #Q;
  endtask

  // One byte MSB first, then the slave's acknowledge
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(s);
    ack = ~s;
  endtask

  // Offset of 7 ns keeps bus edges off the ref_clk edges
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] a,
                           input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    #7;
    start();
    send({dev, 1'b0}, a0);
    send(a, a1);
    send(d, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask

  // Pointer write, repeated start, one byte read with a closing NACK
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] a,
                          output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    #7;
    start();
    send({dev, 1'b0}, a0);
    send(a, a1);
    start();
    send({dev, 1'b1}, a2);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(1'b1);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule // smbus_master_model

// [verif/monitor_sequencer_limit_irq_tb_top.sv]
// Self-checking bench for the monitor core with a converter model inline.
// Assumes the bus master model drives scl and a pull-up sda line.
`timescale 1ns/1ns
module monitor_sequencer_limit_irq_tb_top;
  logic ref_clk, rst, bat_rst, adc_done, intrude_i, ack;
  logic [7:0] adc_data, fan_i, rd;
  logic [7:0] val_tab [20]; // Converter results per slot
  wire scl, sda_pull, sda_o, sda_oe, adc_start, adc_temp, alert_n, sda_line;
  wire [4:0] adc_chan;
  int n_fail = 0, checked = 0, seed = 94, exp_chan = 0, cnt = 0, rt2 = 0;
  localparam logic [6:0] DEV = monitor_pkg::DEV_ADDR_DEFAULT;

  // Pull-up: low when either party pulls
  assign sda_line = ~(sda_pull | sda_oe);

  hw_monitor #(.TICK_CYCLES(4)) uut (.ref_clk(ref_clk), .rst(rst), .bat_rst(bat_rst),
    .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .adc_start(adc_start), .adc_chan(adc_chan), .adc_temp(adc_temp),
    .adc_done(adc_done), .adc_data(adc_data), .fan_i(fan_i), .intrude_i(intrude_i),
    .alert_n(alert_n));
  smbus_master_model host (.scl(scl), .sda_pull(sda_pull), .sda_line(sda_line));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Register read with the acknowledge folded into the comparison count
  task automatic rd_reg(input logic [7:0] a);
    host.read_reg(DEV, a, rd, ack);
    check("read ack", ack, 1'b1);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    host.write_reg(DEV, a, d, ack);
    check("write ack", ack, 1'b1);
  endtask

  // Bounded wait; running out ends the run as a failure
  task automatic wait_alert(input logic lvl);
    int i;
    for (i = 0; i < 500 && alert_n !== lvl; i++) @(negedge ref_clk);
    check("alert_n", alert_n, lvl);
    if (i == 500) complete_run();
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Tach pins toggle every 640 ns on falling edges, off the sampling edge
  initial begin
    fan_i = 8'h00;
    #20;
    forever #640 fan_i = ~fan_i;
  end

  // Converter model: answers three cycles later, checks the slot order
  always @(negedge ref_clk) begin
    adc_done <= 1'b0;
    if (rst) begin
      cnt <= 0;
      exp_chan <= 0;
    end else if (adc_start === 1'b1) begin
      check("adc_chan", adc_chan, exp_chan);
      if (rt2 < 2) check("adc_temp", adc_temp, exp_chan inside {17, 18} ||
                         (exp_chan == 19 && rt2 == 0));
      cnt <= 3;
    end else if (cnt == 1) begin
      adc_done <= 1'b1;
      adc_data <= val_tab[exp_chan];
      exp_chan <= (exp_chan + 1) % 20;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end

  initial begin
    rst = 1'b1;
    bat_rst = 1'b1;
    adc_data = 8'h00;
    intrude_i = 1'b0;
    foreach (val_tab[k]) val_tab[k] = $random(seed);
    val_tab[3] = val_tab[3] | 8'h80; // Slot 3 will exceed a lowered limit
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    bat_rst = 1'b0;
    check("alert_n", alert_n, 1'b1);
    check("adc_start", adc_start, 1'b0);
    check("sda_o", sda_o, 1'b0);
    // Foreign address is refused and starts nothing
    host.write_reg(7'h2F, monitor_pkg::CFG_ADDR, 8'h01, ack);
    check("nack", ack, 1'b0);
    repeat (50) @(negedge ref_clk);
    check("adc_chan", adc_chan, 5'h00);
    $display("test refuse done");
    // Start the sequencer, then read every value back
    wr_reg(monitor_pkg::CFG_ADDR, 8'h01);
    repeat (300) @(negedge ref_clk);
    for (int k = 0; k < 20; k++) begin
      rd_reg(monitor_pkg::VAL_BASE + k[7:0]);
      check("value", rd, val_tab[k]);
    end
    rt2 = 2;
    wr_reg(monitor_pkg::CFG_ADDR, 8'h03);
    rt2 = 1;
    repeat (250) @(negedge ref_clk);
    $display("test sequence done");
    // Lowered high limit, mask, sticky status, clear
    wr_reg(monitor_pkg::HI_BASE + 8'h03, 8'h10);
    wait_alert(1'b0);
    rd_reg(monitor_pkg::STAT_ADDR);
    check("status", rd, 8'h08);
    wr_reg(monitor_pkg::MASK_ADDR, 8'h08);
    repeat (4) @(negedge ref_clk);
    check("masked", alert_n, 1'b1);
    wr_reg(monitor_pkg::HI_BASE + 8'h03, 8'hFF);
    wr_reg(monitor_pkg::MASK_ADDR, 8'h00);
    repeat (4) @(negedge ref_clk);
    check("sticky", alert_n, 1'b0);
    wr_reg(monitor_pkg::STAT_ADDR, 8'h08);
    repeat (4) @(negedge ref_clk);
    check("cleared", alert_n, 1'b1);
    $display("test limits done");
    // Fan counts: 64-cycle period over 8-cycle (divide 2) then 4-cycle ticks
    rd_reg(monitor_pkg::FVAL_BASE);
    check("fan0", rd inside {[7:9]}, 1'b1);
    wr_reg(monitor_pkg::FDIV_ADDR, 8'h54);
    repeat (400) @(negedge ref_clk);
    rd_reg(monitor_pkg::FVAL_BASE);
    check("fan0 div1", rd inside {[15:17]}, 1'b1);
    rd_reg(monitor_pkg::FVAL_BASE + 8'h01);
    check("fan1", rd inside {[7:9]}, 1'b1);
    $display("test fans done");
    // Intrusion latch survives main reset, cleared by its own reset or by a write
    @(negedge ref_clk);
    intrude_i = 1'b1;
    repeat (6) @(negedge ref_clk);
    intrude_i = 1'b0;
    wait_alert(1'b0);
    rst = 1'b1;
    rt2 = 0;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    check("alert_n", alert_n, 1'b1);
    rd_reg(monitor_pkg::CFG_ADDR);
    check("latch", rd, 8'h80);
    @(negedge ref_clk);
    bat_rst = 1'b1;
    @(negedge ref_clk);
    bat_rst = 1'b0;
    rd_reg(monitor_pkg::CFG_ADDR);
    check("latch clr", rd, 8'h00);
    @(negedge ref_clk);
    intrude_i = 1'b1;
    repeat (6) @(negedge ref_clk);
    intrude_i = 1'b0;
    wr_reg(monitor_pkg::CFG_ADDR, 8'h80);
    rd_reg(monitor_pkg::CFG_ADDR);
    check("latch wclr", rd, 8'h00);
    $display("test intrusion done");
    complete_run();
  end
endmodule // monitor_sequencer_limit_irq_tb_top
